// [osm_pkg.sv]
// package: address map constants and carrier types for the option and memory decode
// Overview of operation
// [RULE1] option index pointer at FEH, eight bits, resets to zero, selects option register
// [RULE2] option data port at FFH writes and reads the selected option register
// [RULE3] software loads the index pointer only with valid option register addresses
// [RULE4] internal RAM holds 256 bytes; upper half 80H-FFH reached only indirectly
// [RULE5] lower half 00H-7FH reached by direct and indirect addressing
// [RULE6] direct accesses at 80H-FFH go to special registers, indirect to upper RAM
// [RULE7] external data RAM is a separate space 0000H-02FFH for external moves
// [RULE8] external RAM takes both 8-bit indirect and 16-bit pointer move forms
// [RULE9] locations 00H-1FH form four register banks chosen by two bank-select bits
// [RULE10] bytes 20H-2FH hold 128 bit addresses 00H-7FH, also usable as bytes
// [RULE11] software sets the stack pointer, preferably within E0H to FFH
// [RULE12] special registers at addresses ending in 0 or 8 are bit-addressable
// [RULE13] unassigned special register addresses have no storage; software avoids them
// [RULE14] option registers sit at index 83H, C1H and C2H
// [RULE15] unassigned index values ignore data port writes and read as zero
package osm_pkg;
  // ----------------------------------------
  // special register addresses
  // ----------------------------------------
  localparam logic [7:0] OSM_ADDR_INDEX = 8'hfe;
  localparam logic [7:0] OSM_ADDR_DATA = 8'hff;
  localparam logic [7:0] OSM_INDEX_RESET = 8'h00;
  localparam logic [7:0] OSM_OPT_TRIM = 8'h83;
  localparam logic [7:0] OSM_OPT_CUST0 = 8'hc1;
  localparam logic [7:0] OSM_OPT_CUST1 = 8'hc2;
  // option value defaults; real parts load these from a code option store
  localparam logic [7:0] OSM_TRIM_RESET = 8'h80;
  localparam logic [7:0] OSM_CUST0_RESET = 8'h00;
  localparam logic [7:0] OSM_CUST1_RESET = 8'h00;
  // reserved bits 6,5,1,0 of customer option one
  localparam logic [7:0] OSM_CUST1_MASK = 8'h9c;
  // ----------------------------------------
  // memory map
  // ----------------------------------------
  localparam logic [7:0] OSM_UPPER_BASE = 8'h80;
  localparam logic [7:0] OSM_BANK_TOP = 8'h1f;
  localparam logic [7:0] OSM_BIT_BASE = 8'h20;
  localparam logic [15:0] OSM_XRAM_TOP = 16'h02ff;
  localparam int OSM_IRAM_DEPTH = 256;
  localparam int OSM_XRAM_DEPTH = 768;
  localparam int OSM_BIT_LSB = 3;

  typedef enum logic [1:0] {OSM_MODE_DIRECT, OSM_MODE_INDIRECT, OSM_MODE_BIT} osm_mode_t;

  // one core access to the internal space
  typedef struct packed {
    logic valid;
    logic write;
    osm_mode_t mode;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bit_val;
  } osm_req_t;

  // one external move access
  typedef struct packed {
    logic valid;
    logic write;
    logic wide;
    logic [15:0] addr;
    logic [7:0] wdata;
  } osm_xreq_t;
endpackage

// [osm_xram.sv]
// module: external data RAM behind the external move instructions
`timescale 1ns/1ps
module osm_xram
  import osm_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // access
  input wire osm_xreq_t xreq,
  input wire logic [7:0] dptr_high,
  output logic [7:0] rdata_q,
  output logic hit_q
);
  logic [7:0] mem [OSM_XRAM_DEPTH];
  logic [15:0] eff_addr;
  logic in_range;

  // 8-bit form takes its page from the high pointer byte, as the indirect move does
  assign eff_addr = xreq.wide ? xreq.addr : {dptr_high, xreq.addr[7:0]}; // RULE8
  assign in_range = (eff_addr <= OSM_XRAM_TOP); // RULE7

  always_ff @(posedge SYS_CLK) begin
    if (xreq.valid && xreq.write && in_range) begin
      mem[eff_addr[9:0]] <= xreq.wdata; // RULE7
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
    end else begin
      hit_q <= xreq.valid && in_range;
      if (xreq.valid && !xreq.write) begin
        // out of range reads float to zero rather than alias
        rdata_q <= in_range ? mem[eff_addr[9:0]] : 8'h00; // RULE7
      end
    end
  end
endmodule

// [osm_map.sv]
// module: internal RAM, register-bank, bit area and option register decode
`timescale 1ns/1ps
module osm_map
  import osm_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // internal space access from the core
  input wire osm_req_t REQ,
  input wire logic [1:0] BANK_SELECT,
  output logic [7:0] RDATA,
  output logic RBIT,
  output logic SFR_HIT,
  output logic SFR_BIT_OK,
  // special register access that falls outside this block
  output logic SFR_EXT,
  // register bank location for a working register
  input wire logic [2:0] WREG_NUM,
  output logic [7:0] WREG_ADDR,
  // external move access
  input wire osm_xreq_t XREQ,
  input wire logic [7:0] DPTR_HIGH,
  output logic [7:0] XRDATA,
  output logic XHIT,
  // option values toward the system
  output logic [7:0] OSC_TRIM,
  output logic [7:0] CUST_OPT0,
  output logic [7:0] CUST_OPT1
);
  logic [7:0] iram [OSM_IRAM_DEPTH];
  logic [7:0] index_q;
  logic [7:0] trim_q;
  logic [7:0] cust0_q;
  logic [7:0] cust1_q;
  logic [7:0] rdata_q;
  logic rbit_q;
  logic to_sfr;
  logic [7:0] bit_byte;
  logic [2:0] bit_pos;
  logic opt_wr;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic sfr_space(input osm_mode_t m, input logic [7:0] a);
    sfr_space = (m != OSM_MODE_INDIRECT) && (a >= OSM_UPPER_BASE); // RULE6
  endfunction

  function automatic logic [7:0] opt_read(input logic [7:0] idx, input logic [7:0] t,
                                          input logic [7:0] c0, input logic [7:0] c1);
    case (idx)
      OSM_OPT_TRIM: opt_read = t; // RULE14
      OSM_OPT_CUST0: opt_read = c0;
      OSM_OPT_CUST1: opt_read = c1 & OSM_CUST1_MASK;
      default: opt_read = 8'h00; // RULE15
    endcase
  endfunction

  assign to_sfr = REQ.valid && sfr_space(REQ.mode, REQ.addr);
  // bit address: low 80H in bytes 20H-2FH, upper half in registers ending 0 or 8
  assign bit_byte = REQ.addr[7] ? {REQ.addr[7:3], 3'b000} :
                    (OSM_BIT_BASE + {4'h0, REQ.addr[6:3]}); // RULE10 RULE12
  assign bit_pos = REQ.addr[2:0];
  assign opt_wr = to_sfr && REQ.write && (REQ.mode == OSM_MODE_DIRECT) &&
                  (REQ.addr == OSM_ADDR_DATA);
  assign WREG_ADDR = {3'b000, BANK_SELECT, WREG_NUM}; // RULE9

  // ----------------------------------------
  // option registers
  // ----------------------------------------
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      index_q <= OSM_INDEX_RESET; // RULE1
    end else if (to_sfr && REQ.write && REQ.mode == OSM_MODE_DIRECT &&
                 REQ.addr == OSM_ADDR_INDEX) begin
      index_q <= REQ.wdata; // RULE1
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      trim_q <= OSM_TRIM_RESET;
      cust0_q <= OSM_CUST0_RESET;
      cust1_q <= OSM_CUST1_RESET;
    end else if (opt_wr) begin
      // unassigned index: write dropped, relying on software keeping to valid ones
      case (index_q) // RULE2 RULE3
        OSM_OPT_TRIM: trim_q <= REQ.wdata; // RULE14
        OSM_OPT_CUST0: cust0_q <= REQ.wdata;
        OSM_OPT_CUST1: cust1_q <= REQ.wdata & OSM_CUST1_MASK;
        default: trim_q <= trim_q; // RULE15
      endcase
    end
  end

  // ----------------------------------------
  // internal RAM
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (REQ.valid && REQ.write && !to_sfr) begin
      if (REQ.mode == OSM_MODE_BIT) begin
        iram[bit_byte][bit_pos] <= REQ.bit_val; // RULE10
      end else begin
        iram[REQ.addr] <= REQ.wdata; // RULE4 RULE5
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= 8'h00;
      rbit_q <= 1'b0;
    end else if (REQ.valid && !REQ.write) begin
      if (to_sfr) begin
        // only the option pair lives here; other registers answer on SFR_EXT
        if (REQ.mode == OSM_MODE_DIRECT && REQ.addr == OSM_ADDR_INDEX) begin
          rdata_q <= index_q; // RULE1
        end else if (REQ.mode == OSM_MODE_DIRECT && REQ.addr == OSM_ADDR_DATA) begin
          rdata_q <= opt_read(index_q, trim_q, cust0_q, cust1_q); // RULE2
        end else begin
          rdata_q <= 8'h00; // RULE13
        end
        rbit_q <= 1'b0;
      end else begin
        rdata_q <= iram[REQ.addr]; // RULE4 RULE5
        rbit_q <= iram[bit_byte][bit_pos]; // RULE10
      end
    end
  end

  assign RDATA = rdata_q;
  assign RBIT = rbit_q;
  assign SFR_HIT = to_sfr;
  // a bit address always names a register ending in 0 or 8, so bit mode is always allowed
  assign SFR_BIT_OK = to_sfr && (REQ.mode == OSM_MODE_BIT || REQ.addr[2:0] == 3'h0); // RULE12
  assign SFR_EXT = to_sfr && !(REQ.mode == OSM_MODE_DIRECT &&
                   (REQ.addr == OSM_ADDR_INDEX || REQ.addr == OSM_ADDR_DATA)); // RULE13
  assign OSC_TRIM = trim_q;
  assign CUST_OPT0 = cust0_q;
  assign CUST_OPT1 = cust1_q;

  osm_xram u_xram (
    .SYS_CLK(SYS_CLK),
    .ARST_N(ARST_N),
    .xreq(XREQ),
    .dptr_high(DPTR_HIGH),
    .rdata_q(XRDATA),
    .hit_q(XHIT)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_index_reset: assert property (@(posedge SYS_CLK) $rose(ARST_N) |-> index_q == 8'h00) // RULE1
    else $error("index pointer not zero after reset");
  a_index_load: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE1
    REQ.valid && REQ.write && REQ.mode == OSM_MODE_DIRECT && REQ.addr == 8'hfe
    |=> index_q == $past(REQ.wdata))
    else $error("index pointer did not load");
  a_trim_write: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE14
    opt_wr && index_q == 8'h83 |=> trim_q == $past(REQ.wdata))
    else $error("trim option not written");
  a_data_read: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE2
    REQ.valid && !REQ.write && REQ.mode == OSM_MODE_DIRECT && REQ.addr == 8'hff
    && index_q == 8'hc1 |=> RDATA == cust0_q)
    else $error("data port read mismatch");
  a_bad_index: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE15
    opt_wr && index_q != 8'h83 && index_q != 8'hc1 && index_q != 8'hc2
    |=> $stable(trim_q) && $stable(cust0_q) && $stable(cust1_q))
    else $error("unassigned index changed an option");
  a_indirect_ram: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE6
    REQ.valid && REQ.mode == OSM_MODE_INDIRECT |-> !SFR_HIT)
    else $error("indirect access routed to special registers");
  a_direct_sfr: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE6
    REQ.valid && REQ.mode == OSM_MODE_DIRECT && REQ.addr[7] |-> SFR_HIT)
    else $error("direct upper access missed special registers");
  a_bank_addr: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE9
    WREG_ADDR <= 8'h1f && WREG_ADDR[4:3] == BANK_SELECT)
    else $error("bank location wrong");
  a_sfr_bit: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE12
    SFR_BIT_OK |-> REQ.addr[7] && (REQ.mode == OSM_MODE_BIT || REQ.addr[2:0] == 3'h0))
    else $error("bit access allowed on byte-only register");
  a_bit_mode_ok: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE12
    REQ.valid && REQ.mode == OSM_MODE_BIT && REQ.addr[7] |-> SFR_BIT_OK)
    else $error("special register bit access refused");
  a_wreg_num: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE9
    WREG_ADDR[2:0] == WREG_NUM)
    else $error("working register offset wrong");

  // ----------------------------------------
  // read path, option write, decode flag and external RAM checks
  // ----------------------------------------
  a_index_read: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE1
    REQ.valid && !REQ.write && REQ.mode == OSM_MODE_DIRECT && REQ.addr == 8'hfe
    |=> RDATA == $past(index_q))
    else $error("index pointer read mismatch");
  a_cust0_write: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE14
    opt_wr && index_q == 8'hc1 |=> cust0_q == $past(REQ.wdata))
    else $error("customer option zero not written");
  a_cust1_write: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE14
    opt_wr && index_q == 8'hc2 |=> cust1_q == ($past(REQ.wdata) & 8'h9c))
    else $error("customer option one not written");
  a_cust1_reserved: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE14
    CUST_OPT1[6:5] == 2'b00 && CUST_OPT1[1:0] == 2'b00)
    else $error("reserved option bits set");
  a_opt_read_zero: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE15
    REQ.valid && !REQ.write && REQ.mode == OSM_MODE_DIRECT && REQ.addr == 8'hff &&
    index_q != 8'h83 && index_q != 8'hc1 && index_q != 8'hc2 |=> RDATA == 8'h00)
    else $error("unassigned index read not zero");
  a_sfr_ext_read: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE13
    REQ.valid && !REQ.write && SFR_EXT
    |=> RDATA == 8'h00 && !RBIT)
    else $error("foreign special register read returned data");
  a_sfr_ext_hit: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE13
    SFR_EXT |-> SFR_HIT)
    else $error("foreign register flag outside special space");
  a_lower_direct: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE5
    REQ.valid && !REQ.addr[7] |-> !SFR_HIT)
    else $error("lower RAM access routed to special registers");
  a_xram_range: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE7
    XREQ.valid && XREQ.wide && XREQ.addr > 16'h02ff |=> !XHIT)
    else $error("external RAM answered outside its range");
  a_xram_page: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE8
    XREQ.valid && !XREQ.wide && DPTR_HIGH <= 8'h02 |=> XHIT)
    else $error("8-bit external move missed the RAM");
endmodule

// [osm_core_model.sv]
// partner: behavioural core issuing internal and external data accesses
`timescale 1ns/1ps
module osm_core_model
  import osm_pkg::*;
(
  // clock
  input wire logic SYS_CLK,
  // decode flags from the block
  input wire logic SFR_HIT,
  input wire logic SFR_BIT_OK,
  input wire logic SFR_EXT,
  // requests toward the block
  output osm_req_t REQ,
  output osm_xreq_t XREQ
);
  logic ext_seen = 1'b0;
  initial begin
    REQ = '0;
    XREQ = '0;
  end
  // flags are sampled while the request stands; on release valid drops and every field but mode is inverted
  task automatic acc(input logic wr, input osm_mode_t md, input logic [7:0] a,
                     input logic [7:0] wd, input logic bv, output logic hit, output logic bok);
    if (wr && md == OSM_MODE_DIRECT && a == OSM_ADDR_INDEX &&
        !(wd inside {OSM_OPT_TRIM, OSM_OPT_CUST0, OSM_OPT_CUST1})) begin
      $display("core: index load outside option set");
    end
    // one idle edge first, so back-to-back calls never drive REQ twice in one step
    @(posedge SYS_CLK);
    #1;
    REQ = '{valid: 1'b1, write: wr, mode: md, addr: a, wdata: wd, bit_val: bv};
    #5;
    hit = SFR_HIT;
    bok = SFR_BIT_OK;
    ext_seen = SFR_EXT;
    @(posedge SYS_CLK);
    #1;
    REQ = '{valid: 1'b0, write: ~wr, mode: md, addr: ~a, wdata: ~wd, bit_val: ~bv};
  endtask
  task automatic xacc(input logic wr, input logic wide, input logic [15:0] a,
                      input logic [7:0] wd);
    @(posedge SYS_CLK);
    #1;
    XREQ = '{valid: 1'b1, write: wr, wide: wide, addr: a, wdata: wd};
    @(posedge SYS_CLK);
    #1;
    XREQ = '{valid: 1'b0, write: ~wr, wide: ~wide, addr: ~a, wdata: ~wd};
  endtask
endmodule

// [tb_option_sfr_and_ram_address_map.sv]
// testbench: option registers, internal RAM split, bit area and external RAM
`timescale 1ns/1ps
module tb_option_sfr_and_ram_address_map;
  import osm_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] bank_select = 2'h0;
  logic [2:0] wreg_num = 3'h0;
  logic [7:0] dptr_high = 8'h00;
  logic [7:0] rdata, wreg_addr, xrdata, osc_trim, cust_opt0, cust_opt1;
  logic rbit, sfr_hit, sfr_bit_ok, sfr_ext, xhit, hit, bok;
  osm_req_t req;
  osm_xreq_t xreq;
  int n_fail = 0;
  int checks_done = 0;
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  osm_core_model core (.SYS_CLK(sys_clk), .SFR_HIT(sfr_hit), .SFR_BIT_OK(sfr_bit_ok),
    .SFR_EXT(sfr_ext), .REQ(req), .XREQ(xreq));
  osm_map uut (.SYS_CLK(sys_clk), .ARST_N(arst_n), .REQ(req), .BANK_SELECT(bank_select),
    .RDATA(rdata), .RBIT(rbit), .SFR_HIT(sfr_hit), .SFR_BIT_OK(sfr_bit_ok), .SFR_EXT(sfr_ext),
    .WREG_NUM(wreg_num), .WREG_ADDR(wreg_addr), .XREQ(xreq), .DPTR_HIGH(dptr_high),
    .XRDATA(xrdata), .XHIT(xhit), .OSC_TRIM(osc_trim), .CUST_OPT0(cust_opt0),
    .CUST_OPT1(cust_opt1));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input osm_mode_t md, input logic [7:0] a, input logic [7:0] d);
    core.acc(1'b1, md, a, d, 1'b0, hit, bok);
  endtask
  task automatic rd(input osm_mode_t md, input logic [7:0] a);
    core.acc(1'b0, md, a, 8'h00, 1'b0, hit, bok);
  endtask
  task automatic t_reset;
    chk(osc_trim, OSM_TRIM_RESET);
    chk(cust_opt0, OSM_CUST0_RESET);
    rd(OSM_MODE_DIRECT, OSM_ADDR_INDEX);
    chk(rdata, OSM_INDEX_RESET);
    $display("test reset done");
  endtask
  task automatic t_option;
    logic [7:0] idx [3];
    logic [7:0] exp;
    idx = '{OSM_OPT_TRIM, OSM_OPT_CUST0, OSM_OPT_CUST1};
    for (int i = 0; i < 3; i++) begin
      exp = (i == 2) ? (8'ha5 & OSM_CUST1_MASK) : 8'ha5;
      wr(OSM_MODE_DIRECT, OSM_ADDR_INDEX, idx[i]);
      wr(OSM_MODE_DIRECT, OSM_ADDR_DATA, 8'ha5);
      rd(OSM_MODE_DIRECT, OSM_ADDR_DATA);
      chk(rdata, exp);
      chk((i == 0) ? osc_trim : (i == 1) ? cust_opt0 : cust_opt1, exp);
      rd(OSM_MODE_DIRECT, OSM_ADDR_INDEX);
      chk(rdata, idx[i]);
    end
    // stray index on purpose: writes dropped, reads zero
    wr(OSM_MODE_DIRECT, OSM_ADDR_INDEX, 8'hc3);
    wr(OSM_MODE_DIRECT, OSM_ADDR_DATA, 8'h33);
    rd(OSM_MODE_DIRECT, OSM_ADDR_DATA);
    chk(rdata, 8'h00);
    chk({7'h0, core.ext_seen}, 8'h00);
    chk(osc_trim, 8'ha5);
    $display("test option done");
  endtask
  task automatic t_ram;
    wr(OSM_MODE_INDIRECT, 8'h90, 8'h5a);
    rd(OSM_MODE_DIRECT, 8'h90);
    chk({7'h0, hit}, 8'h01);
    chk(rdata, 8'h00);
    chk({7'h0, core.ext_seen}, 8'h01);
    rd(OSM_MODE_INDIRECT, 8'h90);
    chk(rdata, 8'h5a);
    chk({7'h0, core.ext_seen}, 8'h00);
    // stack area kept in upper RAM, reached indirectly
    wr(OSM_MODE_INDIRECT, 8'he0, 8'h4b);
    rd(OSM_MODE_INDIRECT, 8'he0);
    chk(rdata, 8'h4b);
    wr(OSM_MODE_DIRECT, 8'h10, 8'hc3);
    rd(OSM_MODE_INDIRECT, 8'h10);
    chk(rdata, 8'hc3);
    chk({7'h0, hit}, 8'h00);
    for (int b = 0; b < 4; b++) begin
      @(posedge sys_clk);
      #1;
      bank_select = b[1:0];
      wreg_num = 3'h5;
      #2;
      chk(wreg_addr, {3'h0, b[1:0], 3'h5});
    end
    $display("test ram done");
  endtask
  task automatic t_bit;
    wr(OSM_MODE_DIRECT, 8'h21, 8'h00);
    core.acc(1'b1, OSM_MODE_BIT, 8'h0b, 8'h00, 1'b1, hit, bok);
    rd(OSM_MODE_DIRECT, 8'h21);
    chk(rdata, 8'h08);
    rd(OSM_MODE_BIT, 8'h0b);
    chk({7'h0, rbit}, 8'h01);
    rd(OSM_MODE_BIT, 8'h88);
    chk({7'h0, bok}, 8'h01);
    chk({7'h0, core.ext_seen}, 8'h01);
    rd(OSM_MODE_BIT, 8'h8b);
    chk({7'h0, bok}, 8'h01);
    rd(OSM_MODE_DIRECT, 8'h88);
    chk({7'h0, bok}, 8'h01);
    rd(OSM_MODE_DIRECT, 8'h89);
    chk({7'h0, bok}, 8'h00);
    $display("test bit done");
  endtask
  task automatic t_xram;
    core.xacc(1'b1, 1'b1, 16'h02ff, 8'h3c);
    dptr_high = 8'h02;
    core.xacc(1'b0, 1'b0, 16'h00ff, 8'h00);
    chk(xrdata, 8'h3c);
    chk({7'h0, xhit}, 8'h01);
    dptr_high = 8'h01;
    core.xacc(1'b1, 1'b0, 16'h0010, 8'h96);
    core.xacc(1'b0, 1'b1, 16'h0110, 8'h00);
    chk(xrdata, 8'h96);
    core.xacc(1'b1, 1'b1, 16'h0300, 8'h77);
    core.xacc(1'b0, 1'b1, 16'h0300, 8'h00);
    chk(xrdata, 8'h00);
    chk({7'h0, xhit}, 8'h00);
    $display("test xram done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_option();
    t_ram();
    t_bit();
    t_xram();
    stop_test();
  end
endmodule
